/* File: bench/ext_alu_props.sv */
`timescale 1ns/1ps
`default_nettype none
module ext_alu_props
  import ext_alu_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic instr_valid,
  input wire instr_s instr,
  input wire logic instr_ready,
  input wire logic flags_load,
  input wire logic [DATA_W-1:0] working_register,
  input wire flags_s flags,
  input wire logic skip_next,
  input wire logic done
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // Accepted request
  // ----------------------------------------------------------------
  logic take;
  assign take = instr_valid && instr_ready;

  a_take_answer: assert property (take |=> !done ##[1:2] (done || skip_next))
    else $error("no answer in time after a request");
  a_skip_late: assert property (skip_next |=> !done ##1 done)
    else $error("skip did not add two cycles");
  // Flag loads land one cycle late, so both cycles are exempt
  a_flags_kept: assert property (take && instr.op inside {long_move,
      long_rotate_left, long_rotate_left_to_wreg, long_rotate_right,
      long_rotate_right_to_wreg, long_decrement_skip_zero,
      long_decrement_skip_zero_to_wreg, long_increment_skip_zero,
      long_increment_skip_zero_to_wreg, long_skip_bit_set,
      long_skip_nonzero, long_set_all, long_set_bit, long_nibble_exchange,
      long_nibble_exchange_to_wreg}
      |=> (flags_load || $past(flags_load) || $stable(flags))[*4])
    else $error("flags moved on a flag-free op");
  a_carry_only: assert property (take && instr.op inside
      {long_rotate_left_thru_carry, long_rotate_left_thru_carry_to_wreg,
      long_rotate_right_thru_carry, long_rotate_right_thru_carry_to_wreg}
      |=> (flags_load || $past(flags_load) || $stable({flags.zero,
      flags.sign_range_exceeded_bit, flags.aux_carry_bit,
      flags.true_sign_bit, flags.extended_zero_bit}))[*4])
    else $error("rotate through carry moved other flags");
  a_wreg_kept: assert property (take && instr.op inside {long_move,
      long_or_into_memory, long_rotate_left, long_rotate_left_thru_carry,
      long_rotate_right, long_rotate_right_thru_carry, long_set_bit,
      long_subtract_borrow_to_memory, long_subtract_to_memory,
      long_decrement_skip_zero, long_increment_skip_zero, long_set_all,
      long_skip_bit_set, long_skip_nonzero, long_nibble_exchange}
      |=> $stable(working_register)[*4])
    else $error("memory-target op changed the register");
  a_or_zero: assert property (take && instr.op == long_or_into_wreg
      |-> ##[2:3] done ##0 (flags.zero == (working_register == 8'h00)))
    else $error("zero flag wrong after or");
  a_sub_zero: assert property (take && instr.op == long_subtract
      |-> ##[2:3] done ##0 (flags.zero == (working_register == 8'h00)
      && flags.extended_zero_bit == flags.zero))
    else $error("zero flags wrong after subtract");
  a_skip_wreg: assert property (take && instr.op inside
      {long_decrement_skip_zero_to_wreg, long_increment_skip_zero_to_wreg}
      |-> ##[2:3] (done || skip_next)
      ##0 (skip_next == (working_register == 8'h00)))
    else $error("skip disagrees with register result");

  c_skip: cover property (skip_next);
  c_borrow: cover property (take && instr.op == long_subtract_borrow);
  c_plain_done: cover property (done && !skip_next);
endmodule : ext_alu_props
`default_nettype wire

/* File: bench/tb_extended_memory_alu_ops.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_extended_memory_alu_ops
  import ext_alu_pkg::*;
;
  // k: bit_sel in [6:4], carry in [2], carry out [1], skip [0]
  // d: memory in, register in, memory out, register out
  typedef struct {alu_op_e op; logic [7:0] k; logic [31:0] d;} row_t;
  logic clk_sys, rst_n, instr_valid, instr_ready, flags_load;
  logic skip_next, done, busy, sk;
  instr_s instr;
  mem_wr_s ext_wr;
  flags_s flags_in, flags;
  logic [7:0] working_register;
  int errors = 0, samples_checked = 0, cyc = 0, n, nb;
  row_t rows [26] = '{
    '{long_or_into_wreg, 8'h00, 32'hA55AA5FF},
    '{long_or_into_memory, 8'h06, 32'h30033303},
    '{long_rotate_left, 8'h00, 32'h81000300},
    '{long_rotate_left_to_wreg, 8'h06, 32'hC000C081},
    '{long_rotate_left_thru_carry, 8'h06, 32'h80110111},
    '{long_rotate_left_thru_carry_to_wreg, 8'h00, 32'h7F117FFE},
    '{long_rotate_right, 8'h00, 32'h01228022},
    '{long_rotate_right_to_wreg, 8'h06, 32'h02220201},
    '{long_rotate_right_thru_carry, 8'h02, 32'h01220022},
    '{long_rotate_right_thru_carry_to_wreg, 8'h04, 32'h802280C0},
    '{long_subtract_borrow, 8'h02, 32'h0510050A},
    '{long_subtract_borrow_to_memory, 8'h00, 32'h0505FF05},
    '{long_subtract, 8'h04, 32'h060506FF},
    '{long_subtract_to_memory, 8'h02, 32'h40400040},
    '{long_decrement_skip_zero, 8'h01, 32'h01330033},
    '{long_decrement_skip_zero, 8'h00, 32'h0033FF33},
    '{long_decrement_skip_zero_to_wreg, 8'h00, 32'h05330504},
    '{long_increment_skip_zero, 8'h01, 32'hFF330033},
    '{long_increment_skip_zero_to_wreg, 8'h01, 32'hFF33FF00},
    '{long_skip_bit_set, 8'h31, 32'h08330833},
    '{long_skip_bit_set, 8'h30, 32'hF733F733},
    '{long_skip_nonzero, 8'h01, 32'h01330133},
    '{long_set_all, 8'h00, 32'h1233FF33},
    '{long_set_bit, 8'h70, 32'h00338033},
    '{long_nibble_exchange, 8'h00, 32'hA5335A33},
    '{long_move, 8'h00, 32'h00777777}};

  extended_memory_alu_ops uut (.clk_sys, .rst_n, .instr_valid, .instr,
    .instr_ready, .ext_wr, .flags_in, .flags_load, .working_register,
    .flags, .skip_next, .done, .busy);

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict;
    $display("checks=%0d errors=%0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict

  task automatic run(input alu_op_e op, input logic [11:0] a,
                     input logic [2:0] b);
    @(posedge clk_sys);
    instr_valid <= 1'b1;
    instr <= instr_s'({op, a, b});
    @(posedge clk_sys);
    instr_valid <= 1'b0;
    sk = 1'b0;
    n = 0;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
      if (n == 1) check({7'h0, busy}, 8'h01);
      sk |= (skip_next === 1'b1);
    end while (done !== 1'b1 && n < 12);
    check({7'h0, busy}, 8'h00);
  endtask : run

  task automatic poke(input logic [11:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    ext_wr <= '{we: 1'b1, addr: a, data: v};
    @(posedge clk_sys);
    ext_wr.we <= 1'b0;
  endtask : poke

  // Memory is only visible through the register, via a flag-free swap
  task automatic peek(input logic [11:0] a, output logic [7:0] v);
    run(long_nibble_exchange_to_wreg, a, 3'h0);
    v = {working_register[3:0], working_register[7:4]};
  endtask : peek

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errors++;
      give_verdict();
    end
  end

  initial begin
    logic [7:0] m, w, em, ew, v;
    logic [11:0] a;
    rst_n = 1'b0;
    instr_valid = 1'b0;
    instr = '0;
    ext_wr = '0;
    flags_in = '0;
    flags_load = 1'b0;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    #1;
    check(working_register, WREG_RESET);
    check({2'h0, flags}, 8'h00);
    check({7'h0, instr_ready}, 8'h01);
    run(long_set_all, 12'h001, 3'h0);
    nb = n;
    foreach (rows[i]) begin
      a = 12'h100 + 12'(i) * 12'h07D;
      {m, w, em, ew} = rows[i].d;
      poke(12'h001, {w[3:0], w[7:4]});
      run(long_nibble_exchange_to_wreg, 12'h001, 3'h0);
      poke(a, m);
      @(posedge clk_sys);
      flags_in <= flags_s'({3'h0, rows[i].k[2], 2'h0});
      flags_load <= 1'b1;
      @(posedge clk_sys);
      flags_load <= 1'b0;
      run(rows[i].op, a, rows[i].k[6:4]);
      check(working_register, ew);
      check({7'h0, flags.carry}, {7'h0, rows[i].k[1]});
      check({7'h0, sk}, {7'h0, rows[i].k[0]});
      check(8'(n), 8'(nb + (rows[i].k[0] ? 2 : 0)));
      peek(a, v);
      check(v, em);
      $display("row %0d finished", i);
    end
    // Reset in mid-instruction must drop the pending answer
    @(posedge clk_sys);
    instr_valid <= 1'b1;
    instr <= instr_s'({long_set_all, 12'h002, 3'h0});
    @(posedge clk_sys);
    instr_valid <= 1'b0;
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    check(working_register, WREG_RESET);
    check({6'h0, done, skip_next}, 8'h00);
    check({7'h0, instr_ready}, 8'h01);
    @(posedge clk_sys);
    rst_n <= 1'b1;
    $display("mid-run reset finished");
    give_verdict();
  end
endmodule : tb_extended_memory_alu_ops

bind extended_memory_alu_ops ext_alu_props chk (.clk_sys, .rst_n,
  .instr_valid, .instr, .instr_ready, .flags_load, .working_register,
  .flags, .skip_next, .done);
`default_nettype wire

/* File: design/data_ram.sv */
`timescale 1ns/1ps
`default_nettype none
module data_ram
  import ext_alu_pkg::*;
(
  input wire logic clk_sys,
  input wire logic [ADDR_W-1:0] rd_addr,
  output logic [DATA_W-1:0] rd_data,
  input wire mem_wr_s wr
);

  // ----------------------------------------------------------------
  // Flat storage, one address space for every section
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  always_ff @(posedge clk_sys) begin
    if (wr.we) begin
      mem[wr.addr] <= wr.data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule : data_ram
`default_nettype wire

/* File: design/extended_memory_alu_ops.sv */
// How it works
// - Move stores working register, flags untouched
// - Full flat address, no bank limit
// - OR to register or memory, zero updated
// - Rotate left, top bit wraps, no flags
// - Rotate left through carry, bit seven out
// - Rotate right, bit zero wraps, no flags
// - Rotate right through carry, only carry changes
// - Subtract with borrow, six flags updated
// - Plain subtract, same six flags
// - Carry set when difference not negative
// - Decrement memory, skip when zero
// - Increment memory, skip when zero
// - Decrement into register, skip when zero
// - Increment into register, skip when zero
// - Skipping instruction takes two extra cycles
// - Bit test skips when bit is one
// - Byte test rewrites, skips when nonzero
// - Set all writes ones, no flags
// - Set bit forces one bit only
// - Nibble exchange swaps halves, no flags
`timescale 1ns/1ps
`default_nettype none
module extended_memory_alu_ops
  import ext_alu_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic instr_valid,
  input wire instr_s instr,
  output logic instr_ready,
  input wire mem_wr_s ext_wr,
  input wire flags_s flags_in,
  input wire logic flags_load,
  output logic [DATA_W-1:0] working_register,
  output flags_s flags,
  output logic skip_next,
  output logic done,
  output logic busy
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    st_idle,
    st_read,
    st_exec,
    st_dummy
  } phase_e;

  typedef struct packed {
    phase_e phase;
    instr_s cur;
    logic [1:0] wait_cnt;
    logic [DATA_W-1:0] wreg;
    flags_s flags;
    logic skip;
    logic done;
  } state_s;

  state_s st;
  state_s next_st;

  // ----------------------------------------------------------------
  // Memory and subtractor
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] mem_rd;
  mem_wr_s own_wr;
  mem_wr_s ram_wr;
  logic [ADDR_W-1:0] rd_addr;
  logic [DATA_W-1:0] diff;
  flags_s sub_flags;
  logic use_borrow;

  function automatic logic [DATA_W-1:0] bit_mask(
    input logic [BIT_W-1:0] sel
  );
    bit_mask = ONE << sel;
  endfunction : bit_mask

  function automatic logic is_zero(input logic [DATA_W-1:0] v);
    is_zero = (v == 8'h00);
  endfunction : is_zero

  function automatic logic [DATA_W-1:0] rotate_left_fill(
    input logic [DATA_W-1:0] v,
    input logic fill
  );
    rotate_left_fill = {v[6:0], fill};
  endfunction : rotate_left_fill

  function automatic logic [DATA_W-1:0] rotate_right_fill(
    input logic [DATA_W-1:0] v,
    input logic fill
  );
    rotate_right_fill = {fill, v[7:1]};
  endfunction : rotate_right_fill

  // Separate target tables for memory and register; no op is listed in both
  function automatic logic writes_memory(input alu_op_e op);
    case (op)
      long_move,
      long_or_into_memory,
      long_rotate_left,
      long_rotate_left_thru_carry,
      long_rotate_right,
      long_rotate_right_thru_carry,
      long_subtract_borrow_to_memory,
      long_subtract_to_memory,
      long_decrement_skip_zero,
      long_increment_skip_zero,
      long_skip_nonzero,
      long_set_all,
      long_set_bit,
      long_nibble_exchange: begin
        writes_memory = 1'b1;
      end
      default: begin
        writes_memory = 1'b0;
      end
    endcase
  endfunction : writes_memory

  function automatic logic writes_wreg(input alu_op_e op);
    case (op)
      long_or_into_wreg,
      long_rotate_left_to_wreg,
      long_rotate_left_thru_carry_to_wreg,
      long_rotate_right_to_wreg,
      long_rotate_right_thru_carry_to_wreg,
      long_subtract_borrow,
      long_subtract,
      long_decrement_skip_zero_to_wreg,
      long_increment_skip_zero_to_wreg,
      long_nibble_exchange_to_wreg: begin
        writes_wreg = 1'b1;
      end
      default: begin
        writes_wreg = 1'b0;
      end
    endcase
  endfunction : writes_wreg

  // The core keeps its own writes while busy; others yield to it
  assign ram_wr = own_wr.we ? own_wr : ext_wr;
  // Full address goes straight through, no section select
  assign rd_addr = (st.phase == st_idle) ? instr.addr : st.cur.addr;

  data_ram u_ram (
    .clk_sys(clk_sys),
    .rd_addr(rd_addr),
    .rd_data(mem_rd),
    .wr(ram_wr)
  );

  assign use_borrow = (st.cur.op == long_subtract_borrow) ||
    (st.cur.op == long_subtract_borrow_to_memory);

  sub_unit u_sub (
    .minuend(st.wreg),
    .subtrahend(mem_rd),
    .carry_in(st.flags.carry),
    .use_borrow(use_borrow),
    .zero_prev(st.flags.extended_zero_bit),
    .diff(diff),
    .flags(sub_flags)
  );

  // ----------------------------------------------------------------
  // Execute
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] res;
  logic to_mem;
  logic to_wreg;
  logic take_skip;

  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    next_st.skip = 1'b0;
    own_wr = '0;
    res = mem_rd;
    to_mem = 1'b0;
    to_wreg = 1'b0;
    take_skip = 1'b0;
    if (flags_load) begin
      next_st.flags = flags_in;
    end
    case (st.phase)
      st_idle: begin
        if (instr_valid) begin
          next_st.cur = instr;
          next_st.phase = st_read;
        end
      end
      st_read: begin
        next_st.phase = st_exec;
      end
      st_exec: begin
        case (st.cur.op)
          long_move: begin
            res = st.wreg;
            to_mem = writes_memory(st.cur.op);
          end
          long_or_into_wreg,
          long_or_into_memory: begin
            res = st.wreg | mem_rd;
            to_mem = writes_memory(st.cur.op);
            to_wreg = writes_wreg(st.cur.op);
            next_st.flags.zero = is_zero(res);
          end
          long_rotate_left,
          long_rotate_left_to_wreg: begin
            res = rotate_left_fill(mem_rd, mem_rd[7]);
            to_mem = writes_memory(st.cur.op);
            to_wreg = writes_wreg(st.cur.op);
          end
          long_rotate_left_thru_carry,
          long_rotate_left_thru_carry_to_wreg: begin
            res = rotate_left_fill(mem_rd, st.flags.carry);
            next_st.flags.carry = mem_rd[7];
            to_mem = writes_memory(st.cur.op);
            to_wreg = writes_wreg(st.cur.op);
          end
          long_rotate_right,
          long_rotate_right_to_wreg: begin
            res = rotate_right_fill(mem_rd, mem_rd[0]);
            to_mem = writes_memory(st.cur.op);
            to_wreg = writes_wreg(st.cur.op);
          end
          long_rotate_right_thru_carry,
          long_rotate_right_thru_carry_to_wreg: begin
            res = rotate_right_fill(mem_rd, st.flags.carry);
            next_st.flags.carry = mem_rd[0];
            to_mem = writes_memory(st.cur.op);
            to_wreg = writes_wreg(st.cur.op);
          end
          long_subtract_borrow,
          long_subtract_borrow_to_memory,
          long_subtract,
          long_subtract_to_memory: begin
            res = diff;
            next_st.flags = sub_flags;
            to_mem = writes_memory(st.cur.op);
            to_wreg = writes_wreg(st.cur.op);
          end
          long_decrement_skip_zero,
          long_decrement_skip_zero_to_wreg: begin
            res = mem_rd - ONE;
            to_mem = writes_memory(st.cur.op);
            to_wreg = writes_wreg(st.cur.op);
            take_skip = is_zero(res);
          end
          long_increment_skip_zero,
          long_increment_skip_zero_to_wreg: begin
            res = mem_rd + ONE;
            to_mem = writes_memory(st.cur.op);
            to_wreg = writes_wreg(st.cur.op);
            take_skip = is_zero(res);
          end
          long_skip_bit_set: begin
            take_skip = |(mem_rd & bit_mask(st.cur.bit_sel));
          end
          long_skip_nonzero: begin
            res = mem_rd;
            to_mem = writes_memory(st.cur.op);
            take_skip = ~is_zero(mem_rd);
          end
          long_set_all: begin
            res = ALL_ONES;
            to_mem = writes_memory(st.cur.op);
          end
          long_set_bit: begin
            res = mem_rd | bit_mask(st.cur.bit_sel);
            to_mem = writes_memory(st.cur.op);
          end
          long_nibble_exchange,
          long_nibble_exchange_to_wreg: begin
            res = {mem_rd[3:0], mem_rd[7:4]};
            to_mem = writes_memory(st.cur.op);
            to_wreg = writes_wreg(st.cur.op);
          end
          default: begin
            res = mem_rd;
          end
        endcase
        own_wr.we = to_mem;
        own_wr.addr = st.cur.addr;
        own_wr.data = res;
        if (to_wreg) begin
          next_st.wreg = res;
        end
        if (take_skip) begin
          // Dummy cycles cover the fetch of the suppressed instruction
          next_st.phase = st_dummy;
          next_st.wait_cnt = SKIP_EXTRA_CYCLES - 2'h1;
          next_st.skip = 1'b1;
        end else begin
          next_st.phase = st_idle;
          next_st.done = 1'b1;
        end
      end
      st_dummy: begin
        if (st.wait_cnt == WAIT_ZERO) begin
          next_st.phase = st_idle;
          next_st.done = 1'b1;
        end else begin
          next_st.wait_cnt = st.wait_cnt - 2'h1;
        end
      end
      default: begin
        next_st.phase = st_idle;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st <= '{
        phase: st_idle,
        cur: '0,
        wait_cnt: WAIT_ZERO,
        wreg: WREG_RESET,
        flags: '0,
        skip: 1'b0,
        done: 1'b0
      };
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign instr_ready = (st.phase == st_idle);
  assign busy = (st.phase != st_idle);
  assign working_register = st.wreg;
  assign flags = st.flags;
  assign skip_next = st.skip;
  assign done = st.done;

endmodule : extended_memory_alu_ops
`default_nettype wire

/* File: design/sub_unit.sv */
`timescale 1ns/1ps
`default_nettype none
module sub_unit
  import ext_alu_pkg::*;
(
  input wire logic [DATA_W-1:0] minuend,
  input wire logic [DATA_W-1:0] subtrahend,
  input wire logic carry_in,
  input wire logic use_borrow,
  input wire logic zero_prev,
  output logic [DATA_W-1:0] diff,
  output flags_s flags
);

  logic borrow;
  logic [DATA_W:0] wide;
  logic [4:0] low;

  always_comb begin
    borrow = use_borrow & ~carry_in;
    wide = {1'b0, minuend} - {1'b0, subtrahend} - {8'h00, borrow};
    low = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]} - {4'h0, borrow};
    diff = wide[DATA_W-1:0];
    flags.carry = ~wide[DATA_W];
    flags.aux_carry_bit = ~low[4];
    flags.zero = (diff == 8'h00);
    flags.sign_range_exceeded_bit = (minuend[7] ^ subtrahend[7])
      & (minuend[7] ^ diff[7]);
    flags.true_sign_bit = diff[7] ^ flags.sign_range_exceeded_bit;
    // Chained subtract keeps zero only while every byte was zero
    flags.extended_zero_bit = use_borrow ? (flags.zero & zero_prev)
      : flags.zero;
  end

endmodule : sub_unit
`default_nettype wire

/* File: inc/ext_alu_pkg.sv */
package ext_alu_pkg;

  // ----------------------------------------------------------------
  // Widths and constants
  // ----------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int ADDR_W = 12;
  localparam int BIT_W = 3;
  localparam logic [7:0] ALL_ONES = 8'hFF;
  localparam logic [7:0] ONE = 8'h01;
  localparam logic [7:0] WREG_RESET = 8'h00;
  localparam logic [1:0] SKIP_EXTRA_CYCLES = 2'h2;
  localparam logic [1:0] WAIT_ZERO = 2'h0;

  // ----------------------------------------------------------------
  // Operations
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    op_none,
    long_move,
    long_or_into_wreg,
    long_or_into_memory,
    long_rotate_left,
    long_rotate_left_to_wreg,
    long_rotate_left_thru_carry,
    long_rotate_left_thru_carry_to_wreg,
    long_rotate_right,
    long_rotate_right_to_wreg,
    long_rotate_right_thru_carry,
    long_rotate_right_thru_carry_to_wreg,
    long_subtract_borrow,
    long_subtract_borrow_to_memory,
    long_subtract,
    long_subtract_to_memory,
    long_decrement_skip_zero,
    long_decrement_skip_zero_to_wreg,
    long_increment_skip_zero,
    long_increment_skip_zero_to_wreg,
    long_skip_bit_set,
    long_skip_nonzero,
    long_set_all,
    long_set_bit,
    long_nibble_exchange,
    long_nibble_exchange_to_wreg
  } alu_op_e;

  // Status flags touched by this group
  typedef struct packed {
    logic sign_range_exceeded_bit;
    logic zero;
    logic aux_carry_bit;
    logic carry;
    logic true_sign_bit;
    logic extended_zero_bit;
  } flags_s;

  // Instruction as handed over by the decoder
  typedef struct packed {
    alu_op_e op;
    logic [ADDR_W-1:0] addr;
    logic [BIT_W-1:0] bit_sel;
  } instr_s;

  // Write towards data memory
  typedef struct packed {
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } mem_wr_s;

endpackage : ext_alu_pkg
